// ==== pkg/wtb_pkg.sv ====
// Constants, types and structs for the wide timer byte-access front end.
// Assumes one 25 MHz system clock and a synchronous active-high reset.
package wtb_pkg;

  // ==========================================================================
  // Byte register selects on the 8-bit CPU port
  localparam logic [3:0] A_CNT_LO  = 4'h0;
  localparam logic [3:0] A_CNT_HI  = 4'h1;
  localparam logic [3:0] A_CMPA_LO = 4'h2;
  localparam logic [3:0] A_CMPA_HI = 4'h3;
  localparam logic [3:0] A_CMPB_LO = 4'h4;
  localparam logic [3:0] A_CMPB_HI = 4'h5;
  localparam logic [3:0] A_CAP_LO  = 4'h6;
  localparam logic [3:0] A_CAP_HI  = 4'h7;
  localparam logic [3:0] A_CTRL_A  = 4'h8;
  localparam logic [3:0] A_CTRL_B  = 4'h9;
  localparam logic [3:0] A_FLAG    = 4'hA;
  localparam logic [3:0] A_MASK    = 4'hB;

  // ==========================================================================
  // Limits and field positions
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_MAX    = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT   = 16'h00FF;
  localparam logic [15:0] TOP_9BIT   = 16'h01FF;
  localparam logic [15:0] TOP_10BIT  = 16'h03FF;
  localparam logic [7:0]  ZERO8      = 8'h00;
  localparam int F_OVF  = 0;
  localparam int F_CMPA = 1;
  localparam int F_CMPB = 2;
  localparam int F_CAP  = 3;
  localparam int MODE_LSB = 0;   // mode in control A bits 2:0
  localparam int CAP_EDGE = 6;   // control B bit 6: capture on rising
  localparam int CAP_SRC  = 5;   // control B bit 5: use comparator
  localparam int FILT_EN  = 7;   // control B bit 7: noise filter on
  localparam int FILT_LEN = 4;   // filter samples that must agree

  // ==========================================================================
  // Ceiling source, control A bits 2:0
  typedef enum logic [2:0] {
    WTB_TOP_MAX   = 3'h0,
    WTB_TOP_8     = 3'h1,
    WTB_TOP_9     = 3'h2,
    WTB_TOP_10    = 3'h3,
    WTB_TOP_CMPA  = 3'h4,
    WTB_TOP_CAP   = 3'h5,
    WTB_PWM_CMPA  = 3'h6,
    WTB_PWM_CAP   = 3'h7
  } wtb_mode_t;

  // Clock select, control B bits 2:0
  typedef enum logic [2:0] {
    WTB_CS_OFF  = 3'h0,
    WTB_CS_D1   = 3'h1,
    WTB_CS_D8   = 3'h2,
    WTB_CS_D64  = 3'h3,
    WTB_CS_D256 = 3'h4,
    WTB_CS_D1K  = 3'h5,
    WTB_CS_EXTF = 3'h6,
    WTB_CS_EXTR = 3'h7
  } wtb_cs_t;

  // CPU byte access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } wtb_bus_t;

  // Waveform-generator feed
  typedef struct packed {
    logic match_a;
    logic match_b;
    logic pwm_a_en;
    logic at_top;
    logic at_bottom;
  } wtb_cmp_t;

endpackage : wtb_pkg

// ==== design/wtb_sync.sv ====
// Three-stage pin synchroniser with change acceptance on stages 2 and 3.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/1ns
module wtb_sync import wtb_pkg::*; (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lv;
  } wtb_sync_t;

  wtb_sync_t st, next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2 == st.s3) begin
      next_st.lv = st.s3;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.lv;
endmodule : wtb_sync

// ==== design/wtb_prescale.sv ====
// Prescaler: one-cycle tick enables at clk/8, /64, /256 and /1024.
// Assumes run stays low while the timer is power gated.
`timescale 1ns/1ns
module wtb_prescale import wtb_pkg::*; (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic run,
  output logic      tick8,
  output logic      tick64,
  output logic      tick256,
  output logic      tick1k
);
  typedef struct packed {
    logic [9:0] cnt;
  } wtb_pre_t;

  wtb_pre_t st, next_st;

  always_comb begin
    next_st = st;
    if (run) begin
      next_st.cnt = st.cnt + 10'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick8   = run && (st.cnt[2:0] == 3'h7);
  assign tick64  = run && (st.cnt[5:0] == 6'h3F);
  assign tick256 = run && (st.cnt[7:0] == 8'hFF);
  assign tick1k  = run && (st.cnt == 10'h3FF);
endmodule : wtb_prescale

// ==== design/wtb_top.sv ====
// Wide timer front end: byte writes to 16-bit registers and counter and capture
// reads through one shared high-byte latch, tick selection, ceiling choice, compare and capture.
// Assumes an 8-bit CPU port on clk; pins are asynchronous.
`timescale 1ns/1ns
module wtb_top import wtb_pkg::*; (
  input  wire logic      clk,
  input  wire logic      rst,
  input  wtb_bus_t       bus,
  output logic [7:0]     rdata,
  input  wire logic      timer_power_gate,
  input  wire logic      external_tick_pin,
  input  wire logic      capture_pin,
  input  wire logic      comparator_out,
  output wtb_cmp_t       cmp,
  output logic [3:0]     timer_flag_reg,
  output logic           irq
);
  // ==========================================================================
  // State
  typedef struct packed {
    logic [15:0] count_value;
    logic [15:0] compare_value_a;
    logic [15:0] compare_value_b;
    logic [15:0] buf_a;
    logic [15:0] buf_b;
    logic [15:0] capture_value;
    logic [7:0]  hi_latch;
    logic [7:0]  timer_control_a;
    logic [7:0]  timer_control_b;
    logic [3:0]  flags;
    logic [3:0]  timer_mask_reg;
    logic [7:0]  rdata;
    logic        ext_prev;
    logic        cap_prev;
    logic [FILT_LEN-1:0] filt;
    logic        cap_clean;
  } wtb_state_t;

  wtb_state_t st, next_st;

  logic ext_lvl, cap_lvl, cmp_lvl;
  logic t8, t64, t256, t1k;
  logic run, tick, at_top, cap_evt, cap_raw, ext_edge;
  logic [15:0] top_val;
  wtb_mode_t mode;
  wtb_cs_t   cs;

  assign mode = wtb_mode_t'(st.timer_control_a[MODE_LSB +: 3]);
  assign cs   = wtb_cs_t'(st.timer_control_b[2:0]);
  assign run  = !timer_power_gate && (cs != WTB_CS_OFF);

  wtb_sync u_sync_ext (
    .clk   (clk),
    .rst   (rst),
    .pin   (external_tick_pin),
    .level (ext_lvl)
  );
  wtb_sync u_sync_cap (
    .clk   (clk),
    .rst   (rst),
    .pin   (capture_pin),
    .level (cap_lvl)
  );
  wtb_sync u_sync_cmp (
    .clk   (clk),
    .rst   (rst),
    .pin   (comparator_out),
    .level (cmp_lvl)
  );
  wtb_prescale u_pre (
    .clk     (clk),
    .rst     (rst),
    .run     (run),
    .tick8   (t8),
    .tick64  (t64),
    .tick256 (t256),
    .tick1k  (t1k)
  );

  // ==========================================================================
  // Tick select
  always_comb begin
    ext_edge = 1'b0;
    case (cs)
      WTB_CS_OFF:  tick = 1'b0;
      WTB_CS_D1:   tick = 1'b1;
      WTB_CS_D8:   tick = t8;
      WTB_CS_D64:  tick = t64;
      WTB_CS_D256: tick = t256;
      WTB_CS_D1K:  tick = t1k;
      WTB_CS_EXTF: begin
        ext_edge = st.ext_prev && !ext_lvl;
        tick     = ext_edge;
      end
      WTB_CS_EXTR: begin
        ext_edge = !st.ext_prev && ext_lvl;
        tick     = ext_edge;
      end
      default:     tick = 1'b0;
    endcase
    tick = tick && !timer_power_gate;
  end

  // ==========================================================================
  // Ceiling choice
  always_comb begin
    case (mode)
      WTB_TOP_MAX:  top_val = CNT_MAX;
      WTB_TOP_8:    top_val = TOP_8BIT;
      WTB_TOP_9:    top_val = TOP_9BIT;
      WTB_TOP_10:   top_val = TOP_10BIT;
      WTB_TOP_CMPA: top_val = st.compare_value_a;
      WTB_PWM_CMPA: top_val = st.compare_value_a;
      WTB_TOP_CAP:  top_val = st.capture_value;
      WTB_PWM_CAP:  top_val = st.capture_value;
      default:      top_val = CNT_MAX;
    endcase
  end
  assign at_top = (st.count_value == top_val);

  // ==========================================================================
  // Capture source, filter and edge
  assign cap_raw = st.timer_control_b[CAP_SRC] ? cmp_lvl : cap_lvl;
  always_comb begin
    cap_evt = 1'b0;
    if (st.timer_control_b[CAP_EDGE]) begin
      cap_evt = !st.cap_prev && st.cap_clean;
    end else begin
      cap_evt = st.cap_prev && !st.cap_clean;
    end
  end

  // ==========================================================================
  // Next state
  always_comb begin
    logic [3:0] set_f;
    logic       reload;
    set_f  = 4'h0;
    reload = 1'b0;
    next_st = st;
    next_st.ext_prev = ext_lvl;
    next_st.cap_prev = st.cap_clean;
    next_st.filt = {st.filt[FILT_LEN-2:0], cap_raw};
    if (!st.timer_control_b[FILT_EN]) begin
      next_st.cap_clean = cap_raw;
    end else if (&next_st.filt) begin
      next_st.cap_clean = 1'b1;
    end else if (~|next_st.filt) begin
      next_st.cap_clean = 1'b0;
    end

    // Counting advances only on ticks
    if (tick) begin
      if (at_top) begin
        next_st.count_value = CNT_BOTTOM;
        reload = 1'b1;
      end else begin
        next_st.count_value = st.count_value + 16'h0001;
      end
      if (at_top && (mode == WTB_TOP_MAX || mode[2] == 1'b0)) begin
        set_f[F_OVF] = 1'b1;
      end
      if (at_top && mode[2]) begin
        set_f[F_OVF] = 1'b1;
      end
    end
    if (st.count_value == st.compare_value_a && tick) begin
      set_f[F_CMPA] = 1'b1;
    end
    if (st.count_value == st.compare_value_b && tick) begin
      set_f[F_CMPB] = 1'b1;
    end
    // Buffered compare values take effect at the ceiling when mode bit 1 is set, else every cycle
    if (reload || !mode[1]) begin
      next_st.compare_value_a = st.buf_a;
      next_st.compare_value_b = st.buf_b;
    end
    if (cap_evt && mode != WTB_TOP_CAP && mode != WTB_PWM_CAP) begin
      next_st.capture_value = st.count_value;
      set_f[F_CAP] = 1'b1;
    end

    // CPU port
    next_st.rdata = ZERO8;
    if (bus.rd) begin
      case (bus.addr)
        A_CNT_LO: begin
          next_st.rdata    = st.count_value[7:0];
          next_st.hi_latch = st.count_value[15:8];
        end
        A_CAP_LO: begin
          next_st.rdata    = st.capture_value[7:0];
          next_st.hi_latch = st.capture_value[15:8];
        end
        A_CNT_HI:  next_st.rdata = st.hi_latch;
        A_CAP_HI:  next_st.rdata = st.hi_latch;
        A_CMPA_LO: next_st.rdata = st.buf_a[7:0];
        A_CMPA_HI: next_st.rdata = st.buf_a[15:8];
        A_CMPB_LO: next_st.rdata = st.buf_b[7:0];
        A_CMPB_HI: next_st.rdata = st.buf_b[15:8];
        A_CTRL_A:  next_st.rdata = st.timer_control_a;
        A_CTRL_B:  next_st.rdata = st.timer_control_b;
        A_FLAG:    next_st.rdata = {4'h0, st.flags};
        A_MASK:    next_st.rdata = {4'h0, st.timer_mask_reg};
        default:   next_st.rdata = ZERO8;
      endcase
    end
    if (bus.wr) begin
      case (bus.addr)
        A_CNT_HI, A_CMPA_HI, A_CMPB_HI, A_CAP_HI:
          next_st.hi_latch = bus.wdata;
        A_CNT_LO:
          next_st.count_value = {st.hi_latch, bus.wdata};
        A_CMPA_LO: next_st.buf_a = {st.hi_latch, bus.wdata};
        A_CMPB_LO: next_st.buf_b = {st.hi_latch, bus.wdata};
        A_CAP_LO: begin
          if (mode == WTB_TOP_CAP || mode == WTB_PWM_CAP) begin
            next_st.capture_value = {st.hi_latch, bus.wdata};
          end
        end
        A_CTRL_A:  next_st.timer_control_a = bus.wdata;
        A_CTRL_B:  next_st.timer_control_b = bus.wdata;
        A_MASK:    next_st.timer_mask_reg = bus.wdata[3:0];
        default: ;
      endcase
    end
    // Write-one clears; a same-cycle event wins
    if (bus.wr && bus.addr == A_FLAG) begin
      next_st.flags = (st.flags & ~bus.wdata[3:0]) | set_f;
    end else begin
      next_st.flags = st.flags | set_f;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs
  assign rdata          = st.rdata;
  assign timer_flag_reg = st.flags;
  assign irq            = |(st.flags & st.timer_mask_reg);
  always_comb begin
    cmp.match_a   = (st.count_value == st.compare_value_a);
    cmp.match_b   = (st.count_value == st.compare_value_b);
    cmp.pwm_a_en  = (mode != WTB_PWM_CMPA);
    cmp.at_top    = at_top;
    cmp.at_bottom = (st.count_value == CNT_BOTTOM);
  end

  // ==========================================================================
  // Assertions
  a_low_write_load: assert property (@(posedge clk) disable iff (rst)
    bus.wr && bus.addr == A_CNT_LO |=>
      st.count_value == {$past(st.hi_latch), $past(bus.wdata)})
    else $error("counter low write did not load both bytes");
  a_low_read_latch: assert property (@(posedge clk) disable iff (rst)
    bus.rd && bus.addr == A_CNT_LO && !bus.wr |=>
      st.hi_latch == $past(st.count_value[15:8]) &&
      rdata == $past(st.count_value[7:0]))
    else $error("low read did not latch upper byte");
  a_cmp_read_clean: assert property (@(posedge clk) disable iff (rst)
    bus.rd && bus.addr == A_CMPA_HI && !bus.wr |=>
      $stable(st.hi_latch) && rdata == $past(st.buf_a[15:8]))
    else $error("compare read used the latch");
  a_idle_hold: assert property (@(posedge clk) disable iff (rst)
    cs == WTB_CS_OFF && !bus.wr |=> $stable(st.count_value))
    else $error("counter moved with no source");
  a_bottom_flag: assert property (@(posedge clk) disable iff (rst)
    tick && at_top && !bus.wr |=> cmp.at_bottom)
    else $error("no return to bottom after ceiling");
  a_max_wrap: assert property (@(posedge clk) disable iff (rst)
    mode == WTB_TOP_MAX && st.count_value == CNT_MAX && tick && !bus.wr
      |=> st.count_value == CNT_BOTTOM && st.flags[F_OVF])
    else $error("no wrap at maximum");
  a_match_flag: assert property (@(posedge clk) disable iff (rst)
    tick && cmp.match_b |=> st.flags[F_CMPB])
    else $error("match B flag not set");
  a_cap_same: assert property (@(posedge clk) disable iff (rst)
    $changed(st.capture_value) && !$past(bus.wr) |-> st.flags[F_CAP])
    else $error("capture flag late");
  a_flag_clear: assert property (@(posedge clk) disable iff (rst)
    bus.wr && bus.addr == A_FLAG && bus.wdata[F_CMPB] && !tick
      |=> !st.flags[F_CMPB])
    else $error("flag not cleared by writing one");
  a_pwm_a_off: assert property (@(posedge clk) disable iff (rst)
    mode == WTB_PWM_CMPA |-> !cmp.pwm_a_en)
    else $error("channel A modulated at ceiling");
  a_ctrl_rw: assert property (@(posedge clk) disable iff (rst)
    bus.wr && bus.addr == A_CTRL_B ##1 !bus.wr ##1 bus.rd
      && bus.addr == A_CTRL_B && !bus.wr |=> rdata == $past(bus.wdata, 3))
    else $error("control readback wrong");
endmodule : wtb_top

// ==== verif/wtb_cpu_model.sv ====
// CPU core model: byte and 16-bit accesses on the 8-bit timer port.
// Assumes one-cycle strobes taken at clk and rdata the cycle after a read.
`timescale 1ns/1ns
module wtb_cpu_model import wtb_pkg::*; (
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  output wtb_bus_t        bus
);
  // ==========================================================================
  // Byte cycles
  initial bus = '0;

  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus <= '0;
  endtask : wr8

  task automatic rd8(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ZERO8};
    @(posedge clk);
    bus <= '0;
    #1 d = rdata;
  endtask : rd8

  // ==========================================================================
  // Word pairs, never split by another access so the latch stays ours
  task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
    wr8(lo + 4'h1, v[15:8]);
    wr8(lo, v[7:0]);
  endtask : wr16

  task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
    logic [7:0] l;
    logic [7:0] h;
    rd8(lo, l);
    rd8(lo + 4'h1, h);
    v = {h, l};
  endtask : rd16
endmodule : wtb_cpu_model

// ==== verif/tb_top.sv ====
// Self-checking bench for wtb_top: register rows, limits, flags, capture.
// Assumes the CPU model drives the port and the bench drives the pins.
`timescale 1ns/1ns
module tb_top import wtb_pkg::*;;
  typedef struct packed {
    logic        wide;
    logic [3:0]  addr;
    logic [15:0] val;
    logic [15:0] exp;
  } wtb_row_t;

  localparam wtb_row_t ROWS [7] = '{
    '{1'b1, A_CNT_LO,  16'h1234, 16'h1234},
    '{1'b1, A_CMPA_LO, 16'hA55A, 16'hA55A},
    '{1'b1, A_CMPB_LO, 16'h0F0F, 16'h0F0F},
    '{1'b1, A_CAP_LO,  16'hBEEF, 16'h0000},
    '{1'b0, A_CTRL_A,  16'h00A8, 16'h00A8},
    '{1'b0, A_CTRL_B,  16'h0020, 16'h0020},
    '{1'b0, A_MASK,    16'h0005, 16'h0005}};
  localparam logic [15:0] TOPS [4] = '{CNT_MAX, TOP_8BIT, TOP_9BIT,
                                        TOP_10BIT};
  // Prescaled runs: enabled cycles and the ticks they must give
  localparam wtb_cs_t DIVS [4] = '{WTB_CS_D8, WTB_CS_D64, WTB_CS_D256,
                                   WTB_CS_D1K};
  localparam int SPAN [4] = '{80, 128, 256, 1024};
  localparam logic [15:0] CNTS [4] = '{16'h000A, 16'h0002, 16'h0001,
                                       16'h0001};

  logic       clk;
  logic       rst;
  wtb_bus_t   bus;
  logic [7:0] rdata;
  logic       timer_power_gate;
  logic       external_tick_pin;
  logic       capture_pin;
  logic       comparator_out;
  wtb_cmp_t   cmp;
  logic [3:0] timer_flag_reg;
  logic       irq;
  int         error_cnt;
  int         tests_run;

  wtb_top dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
    .timer_power_gate(timer_power_gate),
    .external_tick_pin(external_tick_pin), .capture_pin(capture_pin),
    .comparator_out(comparator_out), .cmp(cmp),
    .timer_flag_reg(timer_flag_reg), .irq(irq));
  wtb_cpu_model cpu (.clk(clk), .rdata(rdata), .bus(bus));

  always #20 clk = ~clk;

  // ==========================================================================
  // Helpers
  task automatic summarize;
    $display("checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask : chk

  task automatic chk_bit(input string n, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %b, seen %b", n, e, g);
    end
  endtask : chk_bit

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic exp16(input string n, input logic [3:0] a,
                       input logic [15:0] e);
    logic [15:0] v;
    cpu.rd16(a, v);
    chk(n, e, v);
  endtask : exp16

  task automatic exp8(input string n, input logic [3:0] a,
                      input logic [7:0] e);
    logic [7:0] v;
    cpu.rd8(a, v);
    chk(n, {8'h00, e}, {8'h00, v});
  endtask : exp8

  task automatic pin_pulse(input int which);
    @(posedge clk);
    if (which == 0) external_tick_pin <= 1'b1;
    else if (which == 1) capture_pin <= 1'b1;
    else comparator_out <= 1'b1;
    cyc(8);
    @(posedge clk);
    external_tick_pin <= 1'b0;
    capture_pin <= 1'b0;
    comparator_out <= 1'b0;
    cyc(8);
  endtask : pin_pulse

  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    summarize();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    timer_power_gate = 1'b0;
    external_tick_pin = 1'b0;
    capture_pin = 1'b0;
    comparator_out = 1'b0;
    error_cnt = 0;
    tests_run = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    cyc(1);
    chk("reset flags", 16'h0000, {12'h000, timer_flag_reg});
    chk_bit("reset irq", 1'b0, irq);
    // Clock select is off, so every value but the capture value must stand as written
    foreach (ROWS[i]) begin
      if (ROWS[i].wide) begin
        cpu.wr16(ROWS[i].addr, ROWS[i].val);
        exp16("row", ROWS[i].addr, ROWS[i].exp);
      end else begin
        cpu.wr8(ROWS[i].addr, ROWS[i].val[7:0]);
        exp8("row", ROWS[i].addr, ROWS[i].exp[7:0]);
      end
    end
    // One latch serves every wide register write; compare reads bypass it
    cpu.wr8(A_CMPB_HI, 8'h77);
    cpu.wr8(A_CNT_LO, 8'h01);
    exp16("shared latch", A_CNT_LO, 16'h7701);
    exp8("count low", A_CNT_LO, 8'h01);
    exp8("compare hi", A_CMPA_HI, 8'hA5);
    exp8("latched hi", A_CNT_HI, 8'h77);
    // Ceilings of the fixed modes and the bottom
    for (int i = 0; i < 4; i++) begin
      cpu.wr8(A_CTRL_A, {5'h00, i[2:0]});
      cpu.wr16(A_CNT_LO, TOPS[i] - 16'h0001);
      cyc(2);
      chk_bit("below top", 1'b0, cmp.at_top);
      cpu.wr16(A_CNT_LO, TOPS[i]);
      cyc(2);
      chk_bit("at top", 1'b1, cmp.at_top);
    end
    cpu.wr16(A_CNT_LO, CNT_BOTTOM);
    cyc(2);
    chk_bit("at bottom", 1'b1, cmp.at_bottom);
    cpu.wr8(A_CTRL_A, {5'h00, WTB_TOP_CMPA});
    cpu.wr16(A_CNT_LO, 16'hA55A);
    cyc(2);
    chk_bit("cmpa top", 1'b1, cmp.at_top);
    chk_bit("match a", 1'b1, cmp.match_a);
    chk_bit("pwm a on", 1'b1, cmp.pwm_a_en);
    cpu.wr8(A_CTRL_A, {5'h00, WTB_PWM_CMPA});
    cyc(2);
    chk_bit("pwm a off", 1'b0, cmp.pwm_a_en);
    cpu.wr8(A_CTRL_A, {5'h00, WTB_TOP_CAP});
    cpu.wr16(A_CAP_LO, 16'h0321);
    cpu.wr16(A_CNT_LO, 16'h0321);
    cyc(2);
    chk_bit("cap top", 1'b1, cmp.at_top);
    cpu.wr8(A_CTRL_A, {5'h00, WTB_PWM_CAP});
    cyc(2);
    chk_bit("pwm cap top", 1'b1, cmp.at_top);
    chk_bit("pwm a freed", 1'b1, cmp.pwm_a_en);
    cpu.wr8(A_CTRL_A, 8'h00);
    cpu.wr16(A_CNT_LO, 16'h0F0F);
    cyc(2);
    chk_bit("match b", 1'b1, cmp.match_b);
    // Compare flag while counting, then mask and clear
    cpu.wr8(A_MASK, 8'h04);
    cpu.wr16(A_CMPB_LO, 16'h0104);
    cpu.wr16(A_CNT_LO, 16'h0100);
    cpu.wr8(A_CTRL_B, 8'h01);
    cyc(12);
    cpu.wr8(A_CTRL_B, 8'h00);
    cyc(2);
    chk("cmpb flag", 16'h0004, {12'h000, timer_flag_reg});
    chk_bit("irq on", 1'b1, irq);
    exp8("flag read", A_FLAG, 8'h04);
    cpu.wr8(A_FLAG, 8'h04);
    cyc(2);
    chk_bit("irq clear", 1'b0, irq);
    // Overflow at the wrap, masked first
    cpu.wr16(A_CNT_LO, 16'hFFF0);
    cpu.wr8(A_CTRL_B, 8'h01);
    cyc(30);
    cpu.wr8(A_CTRL_B, 8'h00);
    cyc(2);
    chk("ovf flag", 16'h0001, {12'h000, timer_flag_reg});
    chk_bit("irq masked", 1'b0, irq);
    cpu.wr8(A_MASK, 8'h01);
    cyc(2);
    chk_bit("irq ovf", 1'b1, irq);
    cpu.wr8(A_FLAG, 8'h0F);
    // Power gate stops the timer
    timer_power_gate <= 1'b1;
    cpu.wr16(A_CNT_LO, 16'h0050);
    cpu.wr8(A_CTRL_B, 8'h01);
    cyc(10);
    cpu.wr8(A_CTRL_B, 8'h00);
    timer_power_gate <= 1'b0;
    exp16("gated count", A_CNT_LO, 16'h0050);
    // External rising edges, then falling edges
    cpu.wr16(A_CNT_LO, 16'h0000);
    cpu.wr8(A_CTRL_B, {5'h00, WTB_CS_EXTR});
    for (int i = 0; i < 3; i++) pin_pulse(0);
    cpu.wr8(A_CTRL_B, 8'h00);
    exp16("ext count", A_CNT_LO, 16'h0003);
    cpu.wr16(A_CNT_LO, 16'h0000);
    cpu.wr8(A_CTRL_B, {5'h00, WTB_CS_EXTF});
    for (int i = 0; i < 2; i++) pin_pulse(0);
    cpu.wr8(A_CTRL_B, 8'h00);
    exp16("ext fall", A_CNT_LO, 16'h0002);
    // Each divider run lasts a whole number of its periods
    for (int i = 0; i < 4; i++) begin
      cpu.wr16(A_CNT_LO, 16'h0000);
      cpu.wr8(A_CTRL_B, {5'h00, DIVS[i]});
      cyc(SPAN[i] - 2);
      cpu.wr8(A_CTRL_B, 8'h00);
      exp16("div count", A_CNT_LO, CNTS[i]);
    end
    // Capture from the pin, then from the comparator through the filter
    cpu.wr16(A_CNT_LO, 16'h2468);
    cpu.wr8(A_CTRL_B, 8'h40);
    pin_pulse(1);
    chk("cap flag", 16'h0008, {12'h000, timer_flag_reg});
    exp16("cap pin", A_CAP_LO, 16'h2468);
    cpu.wr8(A_FLAG, 8'h08);
    cpu.wr16(A_CNT_LO, 16'h1357);
    cpu.wr8(A_CTRL_B, 8'hE0);
    pin_pulse(2);
    chk("cmp flag", 16'h0008, {12'h000, timer_flag_reg});
    exp16("cap cmp", A_CAP_LO, 16'h1357);
    summarize();
  end
endmodule : tb_top
